//--- adc_irq_regs.vh
// Register offsets, field positions, reset values and timing counts of the converter irq block
`ifndef ADC_IRQ_REGS_VH
`define ADC_IRQ_REGS_VH

`define NUM_LINES          4
`define ADDR_W             8
`define RES_W              12

// Byte offsets on the register bus
`define OFF_FLAG           8'h00
`define OFF_FLAG_CLR       8'h04
`define OFF_OVF            8'h08
`define OFF_OVF_CLR        8'h0c
`define OFF_SEL_1_2        8'h10
`define OFF_SEL_3_4        8'h14
`define OFF_CTL2           8'h18
`define OFF_RESULT0        8'h20
`define OFF_RESULT1        8'h24
`define OFF_RESULT2        8'h28
`define OFF_RESULT3        8'h2c

// Decoded register indices
`define IDX_NONE           4'h0
`define IDX_FLAG           4'h1
`define IDX_FLAG_CLR       4'h2
`define IDX_OVF            4'h3
`define IDX_OVF_CLR        4'h4
`define IDX_SEL_1_2        4'h5
`define IDX_SEL_3_4        4'h6
`define IDX_CTL2           4'h7
`define IDX_RESULT         4'h8

// Field positions
`define SEL_CONT_LO_BIT    0
`define SEL_CONT_HI_BIT    8
`define CTL2_PRESCALE_LSB  0
`define CTL2_PRESCALE_MSB  3
`define CTL2_RES12_BIT     4
`define CTL2_LATE_BIT      5

// Reset values
`define SEL_RESET          32'h0000_0000
`define CTL2_RESET         32'h0000_0000

// Prescale above this value with 12-bit late mode delays the latch
`define PRESCALE_LIMIT     4'h2

// Cycles from conversion event to result latch
`define LAT_SHORT          3'h1
`define LAT_LONG           3'h4

// Bus responses
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

//--- irq_line.v
// One conversion interrupt line: flag, overflow flag and pulse output
`timescale 1ns/100ps
`default_nettype none

module irq_line (
	input  wire clock_i,     // System clock
	input  wire rst_n_i,     // Synchronous reset, active low
	input  wire event_i,     // Conversion event pulse
	input  wire flag_clr_i,  // Write-one clear of the flag
	input  wire ovf_clr_i,   // Write-one clear of the overflow
	input  wire cont_i,      // Continuous interrupt enable
	output reg  flag_o,      // Conversion irq flag
	output reg  ovf_o,       // Irq overflow flag
	output reg  irq_o        // Interrupt pulse
);

	wire fire;
	wire lost;

	// Pulse only when flag is clear, unless continuous mode
	assign fire = event_i & (~flag_o | cont_i);
	// Event onto an already set flag is a lost interrupt
	assign lost = event_i & flag_o;

	// Set beats clear so a colliding event never vanishes
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			flag_o <= 1'b0;
			ovf_o  <= 1'b0;
			irq_o  <= 1'b0;
		end else begin
			irq_o <= fire;
			if (event_i)
				flag_o <= 1'b1;
			else if (flag_clr_i)
				flag_o <= 1'b0;
			if (lost)
				ovf_o <= 1'b1;
			else if (ovf_clr_i)
				ovf_o <= 1'b0;
		end
	end

endmodule // irq_line

`default_nettype wire

//--- result_delay.v
// Result latch that trails the conversion event by a set number of cycles
`timescale 1ns/100ps
`default_nettype none
`include "adc_irq_regs.vh"

module result_delay (
	input  wire        clock_i,   // System clock
	input  wire        rst_n_i,   // Synchronous reset, active low
	input  wire        valid_i,   // New conversion sample
	input  wire [1:0]  line_i,    // Line of the sample
	input  wire [11:0] data_i,    // Sample value
	input  wire [2:0]  latency_i, // Cycles until latch, at least one
	output wire [47:0] res_o,     // Latched results, line 0 lowest
	output wire [3:0]  pend_o     // Line has a result not yet latched
);

	reg [11:0] res_q [0:3];
	reg        pend_q;
	reg [1:0]  pline_q;
	reg [11:0] pdata_q;
	reg [2:0]  cnt_q;
	integer    i;

	assign res_o  = {res_q[3], res_q[2], res_q[1], res_q[0]};
	assign pend_o = pend_q ? (4'h1 << pline_q) : 4'h0;

	// One slot; a new sample pushes the waiting one in at once
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			for (i = 0; i < `NUM_LINES; i = i + 1)
				res_q[i] <= 12'h000;
			pend_q  <= 1'b0;
			pline_q <= 2'h0;
			pdata_q <= 12'h000;
			cnt_q   <= 3'h0;
		end else begin
			if (pend_q && (cnt_q == 3'h1 || valid_i))
				res_q[pline_q] <= pdata_q;
			if (valid_i) begin
				pend_q  <= 1'b1;
				pline_q <= line_i;
				pdata_q <= data_i;
				cnt_q   <= latency_i;
			end else if (pend_q) begin
				cnt_q <= cnt_q - 3'h1;
				if (cnt_q == 3'h1)
					pend_q <= 1'b0;
			end
		end
	end

endmodule // result_delay

`default_nettype wire

//--- adc_irq_ctrl.v
// Converter interrupt flags, overflow, continuous mode and result timing with AXI4-Lite access
//
// How it works
// - Event colliding with clear leaves flag set
// - Continuous enable lets pulses pass set flag
// - Without continuous enable, set flag blocks pulses
// - Lost interrupt sets the line's overflow flag
// - Write one to flag-clear clears flag
// - Write one to overflow-clear clears overflow
// - Flag may rise before result is latched
// - DMA may read three cycles after trigger
// - Late 12-bit, prescale above two: latch trails
// - Idle DMA first read may be stale
// - CPU and coprocessor reads get fresh result
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "adc_irq_regs.vh"

module adc_irq_ctrl (
	input  wire        clock_i,         // System clock, 10 MHz
	input  wire        rst_n_i,         // Synchronous reset, active low
	input  wire [7:0]  s_axi_awaddr_i,  // Write address
	input  wire        s_axi_awvalid_i, // Write address valid
	output wire        s_axi_awready_o, // Write address ready
	input  wire [31:0] s_axi_wdata_i,   // Write data
	input  wire [3:0]  s_axi_wstrb_i,   // Write byte strobes
	input  wire        s_axi_wvalid_i,  // Write data valid
	output wire        s_axi_wready_o,  // Write data ready
	output reg  [1:0]  s_axi_bresp_o,   // Write response
	output reg         s_axi_bvalid_o,  // Write response valid
	input  wire        s_axi_bready_i,  // Write response ready
	input  wire [7:0]  s_axi_araddr_i,  // Read address
	input  wire        s_axi_arvalid_i, // Read address valid
	output wire        s_axi_arready_o, // Read address ready
	output reg  [31:0] s_axi_rdata_o,   // Read data
	output reg  [1:0]  s_axi_rresp_o,   // Read response
	output reg         s_axi_rvalid_o,  // Read data valid
	input  wire        s_axi_rready_i,  // Read data ready
	input  wire        sample_valid_i,  // Conversion done pulse
	input  wire [1:0]  sample_line_i,   // Interrupt line of the conversion
	input  wire [11:0] sample_data_i,   // Converted value
	output wire [3:0]  conversion_interrupt_o, // Interrupt pulses, one per line
	input  wire        dma_rd_i,        // DMA read strobe
	input  wire [1:0]  dma_line_i,      // DMA result select
	output reg  [11:0] dma_data_o,      // DMA read data
	output reg         dma_valid_o      // DMA data valid pulse
);

	// Map a byte address onto a register index
	function [3:0] reg_index;
		input [7:0] addr;
		begin
			case (addr)
			`OFF_FLAG:     reg_index = `IDX_FLAG;
			`OFF_FLAG_CLR: reg_index = `IDX_FLAG_CLR;
			`OFF_OVF:      reg_index = `IDX_OVF;
			`OFF_OVF_CLR:  reg_index = `IDX_OVF_CLR;
			`OFF_SEL_1_2:  reg_index = `IDX_SEL_1_2;
			`OFF_SEL_3_4:  reg_index = `IDX_SEL_3_4;
			`OFF_CTL2:     reg_index = `IDX_CTL2;
			`OFF_RESULT0,
			`OFF_RESULT1,
			`OFF_RESULT2,
			`OFF_RESULT3:  reg_index = `IDX_RESULT;
			default:       reg_index = `IDX_NONE;
			endcase
		end
	endfunction

	// Byte-lane merge for the writable control words
	function [31:0] lane_merge;
		input [31:0] old;
		input [31:0] new_val;
		input [3:0]  strb;
		integer      b;
		begin
			lane_merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (strb[b])
					lane_merge[b*8 +: 8] = new_val[b*8 +: 8];
		end
	endfunction

	// Control registers
	reg  [31:0] sel_1_2_q;
	reg  [31:0] sel_3_4_q;
	reg  [31:0] ctl2_q;

	// Write channel holding
	reg         aw_held_q;
	reg  [7:0]  aw_addr_q;
	reg         w_held_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;

	// Read channel holding
	reg         ar_held_q;
	reg  [7:0]  ar_addr_q;

	wire [3:0]  flag;
	wire [3:0]  ovf;
	wire [3:0]  cont;
	wire [3:0]  event_line;
	wire [47:0] results;
	wire [3:0]  pending;
	wire        wr_go;
	wire [3:0]  wr_idx;
	wire [3:0]  rd_idx;
	wire [1:0]  rd_line;
	wire        rd_stall;
	wire        rd_go;
	wire [3:0]  flag_clr;
	wire [3:0]  ovf_clr;
	wire [2:0]  latency;
	wire        slow_latch;

	// Continuous enables per line
	assign cont = {sel_3_4_q[`SEL_CONT_HI_BIT], sel_3_4_q[`SEL_CONT_LO_BIT],
	               sel_1_2_q[`SEL_CONT_HI_BIT], sel_1_2_q[`SEL_CONT_LO_BIT]};

	// Event goes to its line straight away, ahead of the latch
	assign event_line = sample_valid_i ? (4'h1 << sample_line_i) : 4'h0;

	// Late 12-bit conversions with a slow prescale latch well after the flag
	assign slow_latch = ctl2_q[`CTL2_LATE_BIT] & ctl2_q[`CTL2_RES12_BIT] &
	                    (ctl2_q[`CTL2_PRESCALE_MSB:`CTL2_PRESCALE_LSB] > `PRESCALE_LIMIT);
	assign latency    = slow_latch ? `LAT_LONG : `LAT_SHORT;

	// Write side accepts address and data in either order
	assign s_axi_awready_o = ~aw_held_q & ~s_axi_bvalid_o;
	assign s_axi_wready_o  = ~w_held_q & ~s_axi_bvalid_o;
	assign wr_go  = aw_held_q & w_held_q & ~s_axi_bvalid_o;
	assign wr_idx = reg_index(aw_addr_q);

	// Clear strobes only from lane 0; zeros leave flags alone
	assign flag_clr = (wr_go && wr_idx == `IDX_FLAG_CLR && w_strb_q[0]) ?
	                  w_data_q[3:0] : 4'h0;
	assign ovf_clr  = (wr_go && wr_idx == `IDX_OVF_CLR && w_strb_q[0]) ?
	                  w_data_q[3:0] : 4'h0;

	// Read side
	assign s_axi_arready_o = ~ar_held_q & ~s_axi_rvalid_o;
	assign rd_idx  = reg_index(ar_addr_q);
	assign rd_line = ar_addr_q[3:2];
	// Bus reads of a result wait for its latch, so a handler never sees old data
	assign rd_stall = (rd_idx == `IDX_RESULT) && pending[rd_line];
	assign rd_go    = ar_held_q & ~s_axi_rvalid_o & ~rd_stall;

	// Per-line interrupt logic
	genvar g;
	generate
		for (g = 0; g < `NUM_LINES; g = g + 1) begin : g_line
			irq_line u_line (
				.clock_i    (clock_i),
				.rst_n_i    (rst_n_i),
				.event_i    (event_line[g]),
				.flag_clr_i (flag_clr[g]),
				.ovf_clr_i  (ovf_clr[g]),
				.cont_i     (cont[g]),
				.flag_o     (flag[g]),
				.ovf_o      (ovf[g]),
				.irq_o      (conversion_interrupt_o[g])
			);
		end
	endgenerate

	// Result latch trailing the events
	result_delay u_result (
		.clock_i   (clock_i),
		.rst_n_i   (rst_n_i),
		.valid_i   (sample_valid_i),
		.line_i    (sample_line_i),
		.data_i    (sample_data_i),
		.latency_i (latency),
		.res_o     (results),
		.pend_o    (pending)
	);

	// Write address and data capture, then one response
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			aw_held_q      <= 1'b0;
			aw_addr_q      <= 8'h00;
			w_held_q       <= 1'b0;
			w_data_q       <= 32'h0000_0000;
			w_strb_q       <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata_i;
				w_strb_q <= s_axi_wstrb_i;
			end
			if (wr_go) begin
				aw_held_q      <= 1'b0;
				w_held_q       <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= (wr_idx == `IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	// Control words; writes to read-only words are ignored
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			sel_1_2_q <= `SEL_RESET;
			sel_3_4_q <= `SEL_RESET;
			ctl2_q    <= `CTL2_RESET;
		end else if (wr_go) begin
			case (wr_idx)
			`IDX_SEL_1_2: sel_1_2_q <= lane_merge(sel_1_2_q, w_data_q, w_strb_q);
			`IDX_SEL_3_4: sel_3_4_q <= lane_merge(sel_3_4_q, w_data_q, w_strb_q);
			`IDX_CTL2:    ctl2_q    <= lane_merge(ctl2_q, w_data_q, w_strb_q);
			default:      ctl2_q    <= ctl2_q;
			endcase
		end
	end

	// Read address capture and data return
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			ar_held_q      <= 1'b0;
			ar_addr_q      <= 8'h00;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h0000_0000;
			s_axi_rresp_o  <= `RESP_OKAY;
		end else begin
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				ar_held_q <= 1'b1;
				ar_addr_q <= s_axi_araddr_i;
			end
			if (rd_go) begin
				ar_held_q      <= 1'b0;
				s_axi_rvalid_o <= 1'b1;
				s_axi_rresp_o  <= `RESP_OKAY;
				case (rd_idx)
				`IDX_FLAG:    s_axi_rdata_o <= {28'h0000000, flag};
				`IDX_OVF:     s_axi_rdata_o <= {28'h0000000, ovf};
				`IDX_SEL_1_2: s_axi_rdata_o <= sel_1_2_q;
				`IDX_SEL_3_4: s_axi_rdata_o <= sel_3_4_q;
				`IDX_CTL2:    s_axi_rdata_o <= ctl2_q;
				`IDX_RESULT:  s_axi_rdata_o <= {20'h00000, results[rd_line*12 +: 12]};
				`IDX_FLAG_CLR,
				`IDX_OVF_CLR: s_axi_rdata_o <= 32'h0000_0000;
				default: begin
					s_axi_rdata_o <= 32'h0000_0000;
					s_axi_rresp_o <= `RESP_SLVERR;
				end
				endcase
			end else if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
			end
		end
	end

	// DMA path reads the latch as it stands; no wait, so an early read can be stale
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			dma_data_o  <= 12'h000;
			dma_valid_o <= 1'b0;
		end else begin
			dma_valid_o <= dma_rd_i;
			if (dma_rd_i)
				dma_data_o <= results[dma_line_i*12 +: 12];
		end
	end

endmodule // adc_irq_ctrl

`default_nettype wire

//--- adc_irq_ctrl_asserts.sv
// Port-level checks of the converter interrupt block
`timescale 1ns/100ps
`default_nettype none

module adc_irq_ctrl_asserts (
	input wire logic       clock_i,                // Clock
	input wire logic       rst_n_i,                // Reset, active low
	input wire logic       s_axi_awvalid_i,        // Aw valid
	input wire logic       s_axi_awready_o,        // Aw ready
	input wire logic       s_axi_wvalid_i,         // W valid
	input wire logic       s_axi_wready_o,         // W ready
	input wire logic       s_axi_bvalid_o,         // B valid
	input wire logic       s_axi_bready_i,         // B ready
	input wire logic       s_axi_arvalid_i,        // Ar valid
	input wire logic       s_axi_arready_o,        // Ar ready
	input wire logic       s_axi_rvalid_o,         // R valid
	input wire logic       s_axi_rready_i,         // R ready
	input wire logic       sample_valid_i,         // Conversion done
	input wire logic [1:0] sample_line_i,          // Line of conversion
	input wire logic [3:0] conversion_interrupt_o, // Irq pulses
	input wire logic       dma_rd_i,               // DMA strobe
	input wire logic       dma_valid_o             // DMA data valid
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	// Pulses come only from a conversion on the same line
	irq_one_hot_a: assert property ($onehot0(conversion_interrupt_o))
		else $error("irq pulses on two lines");
	irq_cause_a: assert property (conversion_interrupt_o != 4'h0 |-> $past(sample_valid_i)
		&& conversion_interrupt_o == 4'h1 << $past(sample_line_i))
		else $error("irq pulse without matching conversion");

	// DMA port answers next cycle and never unasked; no wait on the latch
	dma_answer_a: assert property (dma_rd_i |=> dma_valid_o)
		else $error("dma read not answered");
	dma_quiet_a: assert property (!dma_rd_i |=> !dma_valid_o)
		else $error("dma data without request");

	// Bus handshakes; response rises one edge after both beats are held
	write_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write response late");
	write_done_a: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("write response stuck");
	write_busy_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken while response open");
	read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o
		|=> !s_axi_rvalid_o ##[1:40] s_axi_rvalid_o) else $error("read answer timing");
	read_done_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
		else $error("read data stuck");
	read_busy_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read taken while data open");
endmodule // adc_irq_ctrl_asserts

bind adc_irq_ctrl adc_irq_ctrl_asserts adc_irq_ctrl_asserts_i (.clock_i, .rst_n_i,
	.s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o,
	.s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i,
	.sample_valid_i, .sample_line_i, .conversion_interrupt_o, .dma_rd_i, .dma_valid_o);

`default_nettype wire

//--- dma_partner.sv
// Idle DMA channel that reads a result once a conversion interrupt fires
`timescale 1ns/100ps
`default_nettype none

module dma_partner (
	input  wire logic       clock_i,   // System clock
	input  wire logic       rst_n_i,   // Reset, active low
	input  wire logic [3:0] irq_i,     // Conversion interrupt pulses
	input  wire logic [3:0] gap_i,     // Extra cycles before the read
	output var  logic       dma_rd_o,  // Read strobe
	output var  logic [1:0] dma_line_o // Result select
);
	logic [4:0] wait_q;

	// Trigger, optional delay, then one read; a gap acts as a dummy transfer
	always @(posedge clock_i) begin
		dma_rd_o <= 1'b0;
		if (!rst_n_i) begin
			wait_q <= 5'h0;
			dma_line_o <= 2'h0;
		end else if (irq_i != 4'h0) begin
			wait_q <= {1'b0, gap_i} + 5'h1;
			dma_line_o <= irq_i[3] ? 2'h3 : irq_i[2] ? 2'h2 : {1'b0, irq_i[1]};
		end else if (wait_q != 5'h0) begin
			wait_q <= wait_q - 5'h1;
			dma_rd_o <= wait_q == 5'h1;
		end
	end
endmodule // dma_partner

`default_nettype wire

//--- adc_irq_ctrl_tb_top.sv
// Self-checking bench of the converter interrupt block
`timescale 1ns/100ps
`default_nettype none
`include "adc_irq_regs.vh"

module adc_irq_ctrl_tb_top;
	logic        clock_i = 1'b0;
	logic        rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
	logic        s_axi_arvalid_i, s_axi_rready_i, sample_valid_i, dma_rd_i, dma_valid_o;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
	logic        s_axi_rvalid_o, lt;
	logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
	logic [3:0]  s_axi_wstrb_i, conversion_interrupt_o, gap, seen;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, sample_line_i, dma_line_i;
	logic [11:0] sample_data_i, dma_data_o, old, res [4];
	logic [31:0] ctl [3] = '{32'h33, 32'h33, 32'h32};
	logic [3:0]  gaps [3] = '{4'h0, 4'h8, 4'h0};
	integer      seed = 47, fails = 0, compares = 0, l, k;

	adc_irq_ctrl adc_irq_ctrl_i (.clock_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
		.s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
		.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
		.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
		.sample_valid_i, .sample_line_i, .sample_data_i, .conversion_interrupt_o, .dma_rd_i,
		.dma_line_i, .dma_data_o, .dma_valid_o);
	dma_partner dma_partner_i (.clock_i, .rst_n_i, .irq_i(conversion_interrupt_o),
		.gap_i(gap), .dma_rd_o(dma_rd_i), .dma_line_o(dma_line_i));

	// Clock
	always #50 clock_i = ~clock_i;

	task automatic conclude;
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] sv, ex);
		compares++;
		if (sv !== ex) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, ex, sv);
		end
	endtask

	// Expected pulse: a set flag blocks it unless continuous mode
	function automatic logic [3:0] want(input integer ln, input logic set, cont);
		return (!set || cont) ? 4'h1 << ln : 4'h0;
	endfunction

	// Latch trails the pulse only for late 12-bit with prescale above the limit
	function automatic logic late(input logic [31:0] c);
		return c[`CTL2_LATE_BIT] && c[`CTL2_RES12_BIT] && c[3:0] > `PRESCALE_LIMIT;
	endfunction

	// Bus write; hit[2] lands a conversion on the edge where the write acts
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] hit);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		// Each channel is let go at the edge that takes it, in either order
		while (!(aw_ok && w_ok)) begin
			@(posedge clock_i);
			if (!aw_ok && s_axi_awready_o) begin
				aw_ok = 1'b1;
				s_axi_awvalid_i <= 1'b0;
			end
			if (!w_ok && s_axi_wready_o) begin
				w_ok = 1'b1;
				s_axi_wvalid_i <= 1'b0;
			end
		end
		sample_valid_i <= hit[2];
		sample_line_i <= hit[1:0];
		@(posedge clock_i);
		sample_valid_i <= 1'b0;
		// Ready stays up between writes so no edge sees it dropped and raised
		while (!s_axi_bvalid_o) @(posedge clock_i);
		check("bresp", 32'(s_axi_bresp_o), 32'(a == 8'h1c ? `RESP_SLVERR : `RESP_OKAY));
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ex);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do @(posedge clock_i); while (!s_axi_arready_o);
		s_axi_arvalid_i <= 1'b0;
		do @(posedge clock_i); while (!s_axi_rvalid_o);
		check("rdata", s_axi_rdata_o, ex);
		check("rresp", 32'(s_axi_rresp_o), 32'(a == 8'h1c ? `RESP_SLVERR : `RESP_OKAY));
	endtask

	// One conversion; q holds the irq lines in the following cycle
	task automatic smp(input integer ln, input logic [11:0] d, output logic [3:0] q);
		sample_valid_i <= 1'b1;
		sample_line_i <= ln[1:0];
		sample_data_i <= d;
		@(posedge clock_i);
		sample_valid_i <= 1'b0;
		@(posedge clock_i);
		q = conversion_interrupt_o;
	endtask

	// Watchdog, far beyond the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge clock_i);
		fails++;
		conclude();
	end

	initial begin
		{rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 4'h0;
		{s_axi_arvalid_i, s_axi_rready_i, sample_valid_i, gap} <= 7'h00;
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, sample_data_i} <= 60'h0;
		sample_line_i <= 2'h0;
		s_axi_wstrb_i <= 4'hf;
		repeat (6) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		// Reset values, write-only and unmapped places
		rd(`OFF_FLAG, 32'h0);
		rd(`OFF_OVF, 32'h0);
		rd(`OFF_CTL2, `CTL2_RESET);
		rd(`OFF_FLAG_CLR, 32'h0);
		rd(8'h1c, 32'h0);
		wr(8'h1c, 32'hffff_ffff, 3'h0);
		// Per line: blocking flag, overflow and both write-one clears
		for (l = 0; l < 4; l++) begin
			res[l] = 12'($random(seed));
			smp(l, res[l], seen);
			check("irq", 32'(seen), 32'(want(l, 1'b0, 1'b0)));
			rd(`OFF_RESULT0 + 8'(l * 4), 32'(res[l]));
			res[l] = 12'($random(seed));
			smp(l, res[l], seen);
			check("irq", 32'(seen), 32'(want(l, 1'b1, 1'b0)));
			rd(`OFF_OVF, 32'h1 << l);
			wr(`OFF_OVF_CLR, 32'h1 << l, 3'h0);
			rd(`OFF_OVF, 32'h0);
			rd(`OFF_FLAG, 32'h1 << l);
			wr(`OFF_FLAG_CLR, 32'h0, 3'h0);
			rd(`OFF_FLAG, 32'h1 << l);
			wr(`OFF_FLAG_CLR, 32'h1 << l, 3'h0);
			rd(`OFF_FLAG, 32'h0);
		end
		// Continuous mode keeps pulses coming over a set flag
		wr(`OFF_SEL_1_2, 32'h0000_0101, 3'h0);
		wr(`OFF_SEL_3_4, 32'h0000_0101, 3'h0);
		rd(`OFF_SEL_3_4, 32'h0000_0101);
		for (l = 0; l < 4; l++) repeat (2) begin
			res[l] = 12'($random(seed));
			smp(l, res[l], seen);
			check("irq", 32'(seen), 32'(want(l, 1'b1, 1'b1)));
		end
		rd(`OFF_OVF, 32'hf);
		wr(`OFF_FLAG_CLR, 32'hf, 3'h0);
		wr(`OFF_OVF_CLR, 32'hf, 3'h0);
		// Conversion on the clear edge: flag survives, handler clears again
		wr(`OFF_SEL_1_2, 32'h0, 3'h0);
		smp(0, res[0], seen);
		wr(`OFF_FLAG_CLR, 32'h1, 3'h4);
		rd(`OFF_FLAG, 32'h1);
		rd(`OFF_OVF, 32'h1);
		wr(`OFF_FLAG_CLR, 32'h1, 3'h0);
		rd(`OFF_FLAG, 32'h0);
		wr(`OFF_OVF_CLR, 32'h1, 3'h0);
		// Latch timing against a DMA read and a bus read
		for (k = 0; k < 3; k++) begin
			wr(`OFF_CTL2, ctl[k], 3'h0);
			rd(`OFF_CTL2, ctl[k]);
			gap <= gaps[k];
			lt = late(ctl[k]) && gaps[k] == 4'h0;
			old = res[1];
			res[1] = 12'($random(seed));
			smp(1, res[1], seen);
			do @(posedge clock_i); while (!dma_valid_o);
			check("dma", 32'(dma_data_o), 32'(lt ? old : res[1]));
			rd(`OFF_RESULT1, 32'(res[1]));
			wr(`OFF_FLAG_CLR, 32'h2, 3'h0);
		end
		// Bus read issued while a late latch is still pending must wait for it
		wr(`OFF_CTL2, ctl[0], 3'h0);
		res[2] = 12'($random(seed));
		smp(2, res[2], seen);
		check("irq", 32'(seen), 32'(want(2, 1'b0, 1'b1)));
		rd(`OFF_RESULT2, 32'(res[2]));
		conclude();
	end
endmodule // adc_irq_ctrl_tb_top

`default_nettype wire
